// ### pdc_consts.svh
// constants for the pixel clock divider core: control word field positions,
// widths and power-up values; included by bare name from the divider and top-level design files
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_WORD_W 47
`define PDC_LOW_W 13
`define PDC_LOW_RST 13'h1000
`define PDC_SWING_BIT 0
`define PDC_REFSEL_BIT 1
`define PDC_FILT_LSB 2
`define PDC_FILT_W 2
`define PDC_LDIS_BIT 4
`define PDC_PDIS_BIT 5
`define PDC_DDIS_BIT 6
`define PDC_CPI_BIT 7
`define PDC_POL_BIT 8
`define PDC_CPDIS_BIT 9
`define PDC_VDIS_BIT 10
`define PDC_XVCO_BIT 11
`define PDC_VRST_BIT 12
`define PDC_MUX_LSB 13
`define PDC_MUX_W 2
`define PDC_P_LSB 15
`define PDC_P_W 4
`define PDC_P_RST 4'h3
`define PDC_L_LSB 19
`define PDC_L_W 4
`define PDC_L_RST 4'h3
`define PDC_R_LSB 23
`define PDC_R_W 10
`define PDC_R_RST 10'h014
`define PDC_N_LSB 33
`define PDC_N_W 14
`define PDC_N_RST 14'h0078
`define PDC_PL_MOD_W 5
`define PDC_PL_MOD_RST 5'h04
`define PDC_SYNC_W 8
`define PDC_SYNC_RST 8'h01
`define PDC_MUX_RST 2'h0
`define PDC_WORD_RST {`PDC_N_RST, `PDC_R_RST, `PDC_L_RST, `PDC_P_RST, `PDC_MUX_RST, `PDC_LOW_RST}

`endif

// ### pdc_pkg.sv
// types shared by the pixel clock divider core
// assumes pdc_consts.svh supplies the numeric constants
package pdc_pkg;
	typedef enum logic [1:0] {
		PDC_MUX_XTAL = 2'b00,
		PDC_MUX_PLL = 2'b01,
		PDC_MUX_EXT = 2'b10,
		PDC_MUX_XVCO = 2'b11
	} pdc_mux_type;

	typedef enum logic [1:0] {
		PDC_PUMP_OFF = 2'b00,
		PDC_PUMP_UP = 2'b01,
		PDC_PUMP_DN = 2'b10
	} pdc_pump_type;
endpackage

// ### pdc_div.sv
// programmable divider counting source-edge enable pulses
// assumes tick_i is a one-cycle pulse per rising edge of the source level src_i
`timescale 1ns/100ps
`include "pdc_consts.svh"
module pdc_div #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_MOD = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic src_i,
	input wire logic run_i,
	input wire logic high_first_i,
	input wire logic [W-1:0] modulus_i,
	output logic div_o,
	output logic term_o
);
	logic [W-1:0] mod_act;
	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic at_end;
	logic [W-1:0] next_mod;

	// length of the high phase: odd moduli give the extra count to one phase
	function automatic logic [W-1:0] high_len(input logic [W-1:0] m, input logic hf);
		logic [W:0] s;
		s = hf ? ({1'b0, m} + {{W{1'b0}}, 1'b1}) : {1'b0, m};
		high_len = s[W:1];
	endfunction

	// terminal count and the modulus used by the next period
	always_comb
	begin
		at_end = (count >= mod_act - {{(W-1){1'b0}}, 1'b1});
		next_mod = at_end ? modulus_i : mod_act;
		next_count = at_end ? '0 : count + {{(W-1){1'b0}}, 1'b1};
	end

	// new modulus is only taken at terminal count, so no runt pulse
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count <= '0;
			mod_act <= RST_MOD;
		end
		else if (run_i && tick_i)
		begin
			count <= next_count;
			mod_act <= next_mod;
		end
	end

	// output level and terminal pulse; modulus one follows the source
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_o <= 1'b0;
			term_o <= 1'b0;
		end
		else
		begin
			term_o <= run_i && tick_i && at_end;
			if (!run_i)
				div_o <= 1'b0;
			else if (mod_act <= {{(W-1){1'b0}}, 1'b1})
				div_o <= src_i;
			else if (tick_i)
				div_o <= next_count < high_len(next_mod, high_first_i);
		end
	end
endmodule

// ### pdc_top.sv
// pixel clock divider core: serial control word, shadow copy, R/N/P/L dividers,
// phase comparator and output clock multiplexer
// assumes all pins are asynchronous to REF_CLK_I and far slower than it
// What this block does
// - holds a 47-bit volatile control word in a shift register mirrored by shadow
// - whole shift register copies into shadow in one clock cycle
// - enable and direction are sampled on falling strobe edge
// - serial bits shift on rising strobe edge
// - write: last bit with enable high shifts in then copies to shadow
// - read with enable high on first bit reloads shift register from shadow
// - reads never change shadow, parameters or output clocks
// - read bits valid after strobe falls, advance on each rising edge
// - first bit written is first bit read; partial reads allowed
// - multi-bit fields travel least significant bit first
// - bit 1 selects large swing when high; resets low
// - reference divider divides by binary value of bits 24 to 33
// - feedback divider divides oscillator clock by 2 to 16383
// - post divider modulus 1 to 16 from bits 16 to 19
// - pixel clock square for 1 or even; odd has shorter low phase
// - load divider modulus 1 to 16 from bits 20 to 23
// - load clock square for 1 or even; odd has shorter high phase
// - load divider counts the internal multiplexer output
// - a control bit stops the load clock regardless of the gate input
// - phase comparator pumps up, pumps down, or stays off
// - comparator inputs are feedback and reference divider outputs
// - after reset both pixel outputs carry the crystal divided by two
// - bits 14,15 select crystal half, PLL, external, external oscillator
// - post and load fields hold modulus minus one
// - bit 5 high holds load clock low and stops its counter
// - reset values: feedback 120, reference 20, post and load 4, oscillator reset high
`timescale 1ns/100ps
`include "pdc_consts.svh"
module pdc_top (
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire logic SERIAL_STROBE_I,
	input wire logic TRANSFER_ENABLE_I,
	input wire logic DIRECTION_SELECT_I,
	input wire logic SERIAL_DATA_I,
	input wire logic REFERENCE_OSCILLATOR_INPUT_I,
	input wire logic EXTERNAL_CLOCK_INPUT_I,
	input wire logic VCO_CLOCK_I,
	input wire logic LOAD_CLOCK_GATE_INPUT_I,
	output logic SERIAL_DATA_O,
	output logic SERIAL_DATA_OE_O,
	output logic PCLK_O,
	output logic PCLK_N_O,
	output logic CMOS_PCLK_O,
	output logic LOAD_CLOCK_OUT_O,
	output logic LARGE_SWING_O,
	output logic PUMP_UP_O,
	output logic PUMP_DN_O,
	output logic PUMP_CLAMP_O,
	output logic EXTERNAL_OSCILLATOR_PATH_ON_O
);
	logic [`PDC_SYNC_W-1:0] sync1;
	logic [`PDC_SYNC_W-1:0] sync2;
	logic [`PDC_SYNC_W-1:0] prev;
	logic [`PDC_WORD_W-1:0] shift_reg;
	logic [`PDC_WORD_W-1:0] shadow;
	logic lat_en;
	logic lat_read;
	logic strobe_fall;
	logic strobe_rise;
	logic xtal_half;
	logic vco_level;
	logic vco_tick;
	logic ref_tick;
	logic mux_level;
	logic mux_prev;
	logic mux_tick;
	logic ref_term;
	logic fb_term;
	logic post_div;
	logic load_div;
	logic ld_gate;
	logic [`PDC_PL_MOD_W-1:0] post_mod;
	logic [`PDC_PL_MOD_W-1:0] load_mod;
	pdc_pkg::pdc_mux_type mux_sel;
	pdc_pkg::pdc_pump_type pump;
	pdc_pkg::pdc_pump_type next_pump;

	// pins: strobe, enable, direction, data, reference, external, vco, gate
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			sync1 <= `PDC_SYNC_RST; // strobe idles high, no false edge after reset
			sync2 <= `PDC_SYNC_RST;
			prev <= `PDC_SYNC_RST;
		end
		else
		begin
			sync1 <= {LOAD_CLOCK_GATE_INPUT_I, VCO_CLOCK_I, EXTERNAL_CLOCK_INPUT_I,
				REFERENCE_OSCILLATOR_INPUT_I, SERIAL_DATA_I, DIRECTION_SELECT_I,
				TRANSFER_ENABLE_I, SERIAL_STROBE_I};
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// strobe and clock edges seen after the synchroniser
	assign strobe_fall = prev[0] && !sync2[0];
	assign strobe_rise = !prev[0] && sync2[0];
	assign ref_tick = !prev[4] && sync2[4];
	assign vco_level = (shadow[`PDC_XVCO_BIT] && mux_sel == pdc_pkg::PDC_MUX_XVCO) ?
		sync2[5] : sync2[6];
	assign vco_tick = (shadow[`PDC_XVCO_BIT] && mux_sel == pdc_pkg::PDC_MUX_XVCO) ?
		(!prev[5] && sync2[5]) : (!prev[6] && sync2[6]);

	// enable and direction latched on the falling strobe
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			lat_en <= 1'b0;
			lat_read <= 1'b0;
		end
		else if (strobe_fall)
		begin
			lat_en <= sync2[1];
			lat_read <= sync2[2];
		end
	end

	// serial shift register: right shift, first bit ends in bit 0
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			shift_reg <= `PDC_WORD_RST;
		else if (strobe_fall && sync2[2] && sync2[1])
			shift_reg <= shadow;
		else if (strobe_rise)
			shift_reg <= {sync2[3], shift_reg[`PDC_WORD_W-1:1]};
	end

	// shadow copied in one cycle only at the end of a write
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			shadow <= `PDC_WORD_RST;
		else if (strobe_rise && lat_en && !lat_read)
			shadow <= {sync2[`PDC_SYNC_W-5], shift_reg[`PDC_WORD_W-1:1]};
	end

	// read data: bit 0 driven while a read is selected
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			SERIAL_DATA_O <= 1'b0;
			SERIAL_DATA_OE_O <= 1'b0;
		end
		else
		begin
			SERIAL_DATA_OE_O <= lat_read;
			SERIAL_DATA_O <= shift_reg[0];
		end
	end

	// field decode: post and load fields carry modulus minus one
	always_comb
	begin
		mux_sel = pdc_pkg::pdc_mux_type'(shadow[`PDC_MUX_LSB +: `PDC_MUX_W]);
		post_mod = {1'b0, shadow[`PDC_P_LSB +: `PDC_P_W]} + `PDC_PL_MOD_W'(1);
		load_mod = {1'b0, shadow[`PDC_L_LSB +: `PDC_L_W]} + `PDC_PL_MOD_W'(1);
	end

	// crystal divided by two
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			xtal_half <= 1'b0;
		else if (ref_tick)
			xtal_half <= !xtal_half;
	end

	// reference divider
	pdc_div #(.W(`PDC_R_W), .RST_MOD(`PDC_R_RST)) u_ref (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(ref_tick),
		.src_i(sync2[4]),
		.run_i(1'b1),
		.high_first_i(1'b1),
		.modulus_i(shadow[`PDC_R_LSB +: `PDC_R_W]),
		.div_o(),
		.term_o(ref_term)
	);

	// feedback divider on the oscillator clock
	pdc_div #(.W(`PDC_N_W), .RST_MOD(`PDC_N_RST)) u_fb (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(vco_tick),
		.src_i(vco_level),
		.run_i(1'b1),
		.high_first_i(1'b1),
		.modulus_i(shadow[`PDC_N_LSB +: `PDC_N_W]),
		.div_o(),
		.term_o(fb_term)
	);

	// post divider: odd moduli high one count longer
	pdc_div #(.W(`PDC_PL_MOD_W), .RST_MOD(`PDC_PL_MOD_RST)) u_post (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(vco_tick),
		.src_i(vco_level),
		.run_i(1'b1),
		.high_first_i(1'b1),
		.modulus_i(post_mod),
		.div_o(post_div),
		.term_o()
	);

	// output clock multiplexer
	always_comb
	begin
		case (mux_sel)
			pdc_pkg::PDC_MUX_XTAL: mux_level = xtal_half;
			pdc_pkg::PDC_MUX_PLL: mux_level = post_div;
			pdc_pkg::PDC_MUX_EXT: mux_level = sync2[5];
			pdc_pkg::PDC_MUX_XVCO: mux_level = post_div;
			default: mux_level = xtal_half;
		endcase
	end

	// edge of the multiplexer output feeds the load divider
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			mux_prev <= 1'b0;
		else
			mux_prev <= mux_level;
	end
	assign mux_tick = mux_level && !mux_prev;

	// load divider: odd moduli low one count longer, stopped by bit 5
	pdc_div #(.W(`PDC_PL_MOD_W), .RST_MOD(`PDC_PL_MOD_RST)) u_load (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.tick_i(mux_tick),
		.src_i(mux_level),
		.run_i(!shadow[`PDC_LDIS_BIT]),
		.high_first_i(1'b0),
		.modulus_i(load_mod),
		.div_o(load_div),
		.term_o()
	);

	// phase comparator state
	always_comb
	begin
		case (pump)
			pdc_pkg::PDC_PUMP_OFF:
				if (ref_term && !fb_term)
					next_pump = pdc_pkg::PDC_PUMP_UP;
				else if (fb_term && !ref_term)
					next_pump = pdc_pkg::PDC_PUMP_DN;
				else
					next_pump = pdc_pkg::PDC_PUMP_OFF;
			pdc_pkg::PDC_PUMP_UP:
				next_pump = fb_term ? pdc_pkg::PDC_PUMP_OFF : pdc_pkg::PDC_PUMP_UP;
			pdc_pkg::PDC_PUMP_DN:
				next_pump = ref_term ? pdc_pkg::PDC_PUMP_OFF : pdc_pkg::PDC_PUMP_DN;
			default: next_pump = pdc_pkg::PDC_PUMP_OFF;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			pump <= pdc_pkg::PDC_PUMP_OFF;
		else
			pump <= next_pump;
	end

	// pump outputs with polarity, disable and clamp
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			PUMP_UP_O <= 1'b0;
			PUMP_DN_O <= 1'b0;
			PUMP_CLAMP_O <= 1'b1;
		end
		else
		begin
			PUMP_CLAMP_O <= shadow[`PDC_VRST_BIT];
			if (shadow[`PDC_CPDIS_BIT] || shadow[`PDC_VRST_BIT])
			begin
				PUMP_UP_O <= 1'b0;
				PUMP_DN_O <= 1'b0;
			end
			else
			begin
				PUMP_UP_O <= (pump == pdc_pkg::PDC_PUMP_UP) ^ shadow[`PDC_POL_BIT] &&
					pump != pdc_pkg::PDC_PUMP_OFF;
				PUMP_DN_O <= (pump == pdc_pkg::PDC_PUMP_DN) ^ shadow[`PDC_POL_BIT] &&
					pump != pdc_pkg::PDC_PUMP_OFF;
			end
		end
	end

	// output clocks and static controls
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			PCLK_O <= 1'b0;
			PCLK_N_O <= 1'b0;
			CMOS_PCLK_O <= 1'b0;
			LOAD_CLOCK_OUT_O <= 1'b0;
			LARGE_SWING_O <= 1'b0;
			EXTERNAL_OSCILLATOR_PATH_ON_O <= 1'b0;
			ld_gate <= 1'b0;
		end
		else
		begin
			PCLK_O <= mux_level && !shadow[`PDC_DDIS_BIT];
			PCLK_N_O <= !mux_level && !shadow[`PDC_DDIS_BIT];
			CMOS_PCLK_O <= mux_level && !shadow[`PDC_PDIS_BIT];
			LARGE_SWING_O <= shadow[`PDC_SWING_BIT];
			EXTERNAL_OSCILLATOR_PATH_ON_O <= shadow[`PDC_XVCO_BIT];
			ld_gate <= sync2[7];
			if (shadow[`PDC_LDIS_BIT])
				LOAD_CLOCK_OUT_O <= 1'b0;
			else if (ld_gate)
				LOAD_CLOCK_OUT_O <= load_div;
		end
	end

	chk_write_copy: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_rise && lat_en && !lat_read |=>
		shadow == {$past(sync2[3]), $past(shift_reg[`PDC_WORD_W-1:1])})
		else $error("shadow not loaded from shift register");
	chk_read_keep: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		lat_read |=> $stable(shadow))
		else $error("read changed shadow");
	chk_read_load: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_fall && sync2[2] && sync2[1] |=> shift_reg == $past(shadow))
		else $error("read transfer missed");
	chk_strobe_sample: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_fall |=> lat_read == $past(sync2[2]) && lat_en == $past(sync2[1]))
		else $error("enable or direction not sampled");
	chk_data_follow: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_fall && sync2[2] && sync2[1] |=> ##1 SERIAL_DATA_O == $past(shadow[0], 2))
		else $error("first read bit not from shadow");
	chk_load_stop: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		shadow[`PDC_LDIS_BIT] |=> !LOAD_CLOCK_OUT_O)
		else $error("load clock not held low");
	chk_swing_bit: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		$changed(shadow[`PDC_SWING_BIT]) |=> LARGE_SWING_O == $past(shadow[`PDC_SWING_BIT]))
		else $error("swing output wrong");
	chk_pump_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		shadow[`PDC_VRST_BIT] |=> !PUMP_UP_O && !PUMP_DN_O)
		else $error("pump active while clamped");
	chk_pump_excl: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		!(PUMP_UP_O && PUMP_DN_O))
		else $error("pump up and down together");
	cov_write: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_rise && lat_en && !lat_read);
	cov_read_xfer: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		strobe_fall && sync2[2] && sync2[1]);
	cov_pll_sel: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		mux_sel == pdc_pkg::PDC_MUX_PLL && PUMP_UP_O);
endmodule

// ### pdc_host.sv
// host model: drives the serial strobe interface one bit at a time
// assumes clk_i is the core clock; each strobe level lasts at least 6 cycles
`timescale 1ns/100ps
module pdc_host (
	input wire logic clk_i,
	input wire logic data_i,
	output logic strobe_o,
	output logic enable_o,
	output logic dir_o,
	output logic data_o
);
	// idle: strobe high, no transfer, write direction
	initial
	begin
		strobe_o = 1'b1;
		enable_o = 1'b0;
		dir_o = 1'b0;
		data_o = 1'b0;
	end

	// one bit: controls settle, strobe low with data, sample, strobe high
	task automatic bit_cycle(input logic en, input logic dir, input logic d, output logic q);
		@(negedge clk_i);
		enable_o = en;
		dir_o = dir;
		repeat (4) @(negedge clk_i);
		strobe_o = 1'b0;
		data_o = d;
		repeat (8) @(negedge clk_i);
		q = data_i;
		strobe_o = 1'b1;
		repeat (6) @(negedge clk_i);
	endtask

	// full word, first bit is control bit 1; commit raises enable on the last bit
	task automatic write_word(input logic [46:0] w, input logic commit);
		logic q;
		for (int i = 0; i < 47; i++)
			bit_cycle(commit && i == 46, 1'b0, w[i], q);
		enable_o = 1'b0;
	endtask

	// leading n bits; refresh asks for the shadow copy on the first bit
	task automatic read_word(input int n, input logic refresh, output logic [46:0] r);
		r = '0;
		for (int i = 0; i < n; i++)
			bit_cycle(refresh && i == 0, 1'b1, ~data_o, r[i]);
		enable_o = 1'b0;
	endtask
endmodule

// ### pdc_top_bench.sv
// self-checking bench for the pixel clock divider core
// assumes the host model drives the strobe pins; clocks made on falling edges
`timescale 1ns/100ps
module pdc_top_bench;
	localparam logic [46:0] DEF_WORD = {14'h0078, 10'h014, 4'h3, 4'h3, 2'h0, 13'h1000};
	localparam logic [46:0] W1 = {14'h0078, 10'h014, 4'h4, 4'h4, 2'h1, 13'h0801};
	localparam logic [46:0] W2 = {14'h0078, 10'h014, 4'h4, 4'h4, 2'h1, 13'h0811};
	localparam logic [46:0] W3 = {14'h0078, 10'h014, 4'h1, 4'h4, 2'h2, 13'h1000};
	logic clk, rst_n, stb, en, dir, sdi, sdo, oe, xtal, vco, ext;
	logic pclk, pclk_n, cpclk, load_clock_out, swing, pu, pd, clamp, xop;
	int failures, n_compared, xcnt, vcnt, ecnt;

	// clock and slow source clocks
	initial clk = 1'b0;
	always #25 clk = ~clk;
	always @(negedge clk)
	begin
		xcnt <= (xcnt == 7) ? 0 : xcnt + 1;
		vcnt <= (vcnt == 4) ? 0 : vcnt + 1;
		ecnt <= (ecnt == 5) ? 0 : ecnt + 1;
		if (ecnt == 5)
			ext <= ~ext;
		if (xcnt == 7)
			xtal <= ~xtal;
		if (vcnt == 4)
			vco <= ~vco;
	end

	pdc_host host_u (.clk_i(clk), .data_i(sdo), .strobe_o(stb), .enable_o(en),
		.dir_o(dir), .data_o(sdi));

	pdc_top dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .SERIAL_STROBE_I(stb),
		.TRANSFER_ENABLE_I(en), .DIRECTION_SELECT_I(dir), .SERIAL_DATA_I(sdi),
		.REFERENCE_OSCILLATOR_INPUT_I(xtal), .EXTERNAL_CLOCK_INPUT_I(ext),
		.VCO_CLOCK_I(vco), .LOAD_CLOCK_GATE_INPUT_I(1'b1), .SERIAL_DATA_O(sdo),
		.SERIAL_DATA_OE_O(oe), .PCLK_O(pclk), .PCLK_N_O(pclk_n), .CMOS_PCLK_O(cpclk),
		.LOAD_CLOCK_OUT_O(load_clock_out), .LARGE_SWING_O(swing), .PUMP_UP_O(pu), .PUMP_DN_O(pd),
		.PUMP_CLAMP_O(clamp), .EXTERNAL_OSCILLATOR_PATH_ON_O(xop));

	// compare of words and single bits
	task automatic chk_word(input logic [46:0] got, input logic [46:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// compare of measured cycle counts
	task automatic chk_num(input int got, input int exp);
		n_compared++;
		if (got != exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// static outputs: swing, clamp, external path
	task automatic chk_pins(input logic [2:0] exp);
		chk_word({44'h0, swing, clamp, xop}, {44'h0, exp});
	endtask

	function automatic logic pick(input int sel);
		return (sel == 0) ? cpclk : load_clock_out;
	endfunction

	// high and low phase lengths in core cycles, each wait bounded
	task automatic meas(input int sel, output int hi, output int lo);
		int k;
		hi = 0;
		lo = 0;
		k = 0;
		while (pick(sel) !== 1'b0 && k < 3000)
		begin
			@(negedge clk);
			k++;
		end
		while (pick(sel) !== 1'b1 && k < 3000)
		begin
			@(negedge clk);
			k++;
		end
		while (pick(sel) === 1'b1 && hi < 3000)
		begin
			@(negedge clk);
			hi++;
		end
		while (pick(sel) === 1'b0 && lo < 3000)
		begin
			@(negedge clk);
			lo++;
		end
	endtask

	// power-up word, crystal half on the outputs, load at an eighth
	task automatic t_reset;
		logic [46:0] r;
		int hi, lo;
		chk_pins(3'b010);
		host_u.read_word(47, 1'b1, r);
		chk_word(r, DEF_WORD);
		chk_word({46'h0, oe}, 47'h1);
		meas(0, hi, lo);
		chk_num(hi, 16);
		chk_num(lo, 16);
		chk_word({46'h0, pclk_n}, {46'h0, ~pclk});
		meas(1, hi, lo);
		chk_num(hi + lo, 128);
		chk_num(hi, 64);
	endtask

	// committed write changes everything at once; odd moduli duty
	task automatic t_write;
		logic [46:0] r;
		int hi, lo;
		host_u.write_word(W1, 1'b1);
		chk_pins(3'b101);
		chk_word({46'h0, oe}, 47'h0);
		host_u.read_word(47, 1'b1, r);
		chk_word(r, W1);
		repeat (200) @(negedge clk);
		meas(0, hi, lo);
		chk_num(hi, 30);
		chk_num(lo, 20);
		meas(1, hi, lo);
		chk_num(hi, 100);
		chk_num(lo, 150);
	endtask

	// shifting without commit and partial reads leave the settings alone
	task automatic t_no_side_effect;
		logic [46:0] r;
		int hi, lo;
		host_u.write_word(47'h0, 1'b0);
		chk_pins(3'b101);
		host_u.read_word(10, 1'b1, r);
		chk_word(r, {37'h0, W1[9:0]});
		host_u.read_word(47, 1'b1, r);
		chk_word(r, W1);
		chk_pins(3'b101);
		meas(0, hi, lo);
		chk_num(hi, 30);
	endtask

	// load disable bit holds the load clock low with the gate input high
	task automatic t_load_off;
		int k;
		host_u.write_word(W2, 1'b1);
		repeat (400) @(negedge clk);
		k = 0;
		repeat (400)
		begin
			@(negedge clk);
			if (load_clock_out !== 1'b0)
				k++;
		end
		chk_num(k, 0);
	endtask

	// passthru source on the outputs; load divides the multiplexer output
	task automatic t_passthru;
		int hi, lo;
		host_u.write_word(W3, 1'b1);
		repeat (200) @(negedge clk);
		meas(0, hi, lo);
		chk_num(hi, 6);
		chk_num(lo, 6);
		meas(1, hi, lo);
		chk_num(hi, 12);
		chk_num(lo, 12);
	endtask

	// verdict and end of run
	task automatic results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		results;
	end

	// reset then scenarios
	initial
	begin
		failures = 0;
		n_compared = 0;
		xcnt = 0;
		vcnt = 0;
		ecnt = 0;
		ext = 1'b0;
		xtal = 1'b0;
		vco = 1'b0;
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		t_write;
		t_no_side_effect;
		t_load_off;
		t_passthru;
		results;
	end
endmodule
